// >>> rtl/ioms_intercept_check.sv
// Port I/O and register access intercept checker with AXI4-Lite status view.
// Assumes a byte-wide memory read port that answers each request once.
`timescale 1ns/1ns
module ioms_intercept_check
   import ioms_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Guest entry
   input wire logic entryStart,
   input wire logic [63:0] portBitmapBaseAddress,
   input wire logic [63:0] registerBitmapBaseAddress,
   input wire logic portIoInterceptEnable,
   input wire logic registerInterceptEnable,
   output logic entryDone,
   output logic entryInvalid,
   // Instruction check request
   input wire logic reqValid,
   input wire logic reqIsReg,
   input wire logic [15:0] reqPort,
   input wire logic [2:0] reqOperandSize,
   input wire logic [2:0] reqAddrSize,
   input wire logic [2:0] reqSegment,
   input wire logic reqRepeat,
   input wire logic reqString,
   input wire logic reqIsInput,
   input wire logic [63:0] reqNextRip,
   input wire logic [31:0] reqRegNum,
   input wire logic reqRegWrite,
   input wire logic reqPreFault,
   input wire logic reqPostFault,
   output logic reqReady,
   // Instruction check answer
   output logic respValid,
   output logic respFault,
   output logic respExit,
   output logic respExecute,
   output logic [15:0] exitCode,
   output logic [31:0] exitQualifierOne,
   output logic [63:0] exitQualifierTwo,
   // Permission map reads
   output logic memReqValid,
   output logic [63:0] memAddr,
   input wire logic memReqReady,
   input wire logic memRespValid,
   input wire logic [7:0] memData,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   typedef struct packed
   {
      ioms_state_t st;
      logic [63:0] portBase;
      logic [63:0] regBase;
      logic portEn;
      logic regEn;
      logic [6:0] paBits;
      logic entryDone;
      logic entryInvalid;
      logic reqReady;
      logic isReg;
      logic postFault;
      logic second;
      logic hit;
      logic [15:0] bitMask;
      logic [13:0] byteIdx;
      logic [31:0] qual1;
      logic [63:0] qual2;
      logic respValid;
      logic respFault;
      logic respExit;
      logic respExecute;
      logic [15:0] exitCode;
      logic [31:0] qualOne;
      logic [63:0] qualTwo;
      logic memReqValid;
      logic [63:0] memAddr;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic lastInvalid;
   } ioms_regs_t;

   ioms_regs_t r;
   ioms_regs_t next_r;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Map end at or above 2**paBits is illegal
   function automatic logic beyondLimit(input logic [63:0] base, input logic [63:0] last, input logic [6:0] bits);
      logic [64:0] endAddr;
      logic [64:0] limit;
      endAddr = {1'b0, base & PAGE_MASK} + {1'b0, last};
      limit = 65'h1 << bits;
      return endAddr >= limit;
   endfunction

   // Register number to map byte; mapped low when unmapped
   function automatic logic [13:0] regByte(input logic [31:0] num, output logic mapped);
      logic [12:0] off;
      off = REG_OFF_LOW;
      mapped = 1'b1;
      if (num[31:13] == REG_RANGE_LOW)
         off = REG_OFF_LOW;
      else if (num[31:13] == REG_RANGE_HI0)
         off = REG_OFF_HI0;
      else if (num[31:13] == REG_RANGE_HI1)
         off = REG_OFF_HI1;
      else
         mapped = 1'b0;
      return {1'b0, off + {2'h0, num[12:2]}};
   endfunction

   // Read data for a register offset; err high when unmapped
   function automatic logic [31:0] readReg(input ioms_regs_t s, input logic [7:0] a, output logic err);
      err = 1'b0;
      unique case (a)
         ADDR_QUAL1: return s.qual1;
         ADDR_QUAL2_LO: return s.qual2[31:0];
         ADDR_QUAL2_HI: return s.qual2[63:32];
         ADDR_STATUS: return {16'h0, s.exitCode[15:0]} ^ {31'h0, 1'b0} | {15'h0, s.lastInvalid, 16'h0};
         ADDR_PA_BITS: return {25'h0, s.paBits};
         default:
         begin
            err = 1'b1;
            return 32'h0;
         end
      endcase
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      logic mapped;
      logic [13:0] rb;
      logic [3:0] nBytes;
      logic [23:0] span;
      logic rdErr;
      logic [31:0] rdVal;
      mapped = 1'b0;
      rb = 14'h0;
      nBytes = 4'h0;
      span = 24'h0;
      rdErr = 1'b0;
      rdVal = 32'h0;
      next_r = r;
      next_r.entryDone = 1'b0;
      next_r.respValid = 1'b0;

      // Guest entry loads map bases and enables
      if (entryStart)
      begin
         next_r.portBase = portBitmapBaseAddress & PAGE_MASK;
         next_r.regBase = registerBitmapBaseAddress & PAGE_MASK;
         next_r.portEn = portIoInterceptEnable;
         next_r.regEn = registerInterceptEnable;
         next_r.entryDone = 1'b1;
         next_r.entryInvalid = beyondLimit(portBitmapBaseAddress, PORT_MAP_LAST, r.paBits)
            | beyondLimit(registerBitmapBaseAddress, REG_MAP_LAST, r.paBits);
         next_r.lastInvalid = next_r.entryInvalid;
         if (next_r.entryInvalid)
            next_r.exitCode = EXIT_INVALID;
      end

      unique case (r.st)
         ST_IDLE:
         begin
            if (reqValid && r.reqReady && !entryStart)
            begin
               next_r.reqReady = 1'b0;
               next_r.isReg = reqIsReg;
               next_r.postFault = reqPostFault;
               next_r.hit = 1'b0;
               next_r.second = 1'b0;
               next_r.qualTwo = 64'h0;
               if (reqPreFault)
               begin
                  next_r.respFault = 1'b1;
                  next_r.st = ST_DONE;
               end
               else if (reqIsReg)
               begin
                  rb = regByte(reqRegNum, mapped);
                  next_r.qualOne = {31'h0, reqRegWrite};
                  next_r.byteIdx = rb;
                  next_r.bitMask = 16'h1 << {reqRegNum[1:0], reqRegWrite};
                  if (!r.regEn)
                     next_r.st = ST_DECIDE;
                  else if (!mapped)
                  begin
                     next_r.hit = 1'b1;
                     next_r.st = ST_DECIDE;
                  end
                  else
                     next_r.st = ST_FETCH;
               end
               else
               begin
                  nBytes = {1'b0, reqOperandSize[2], reqOperandSize[1], reqOperandSize[0]};
                  span = (24'h1 << nBytes) - 24'h1;
                  next_r.bitMask = span[15:0] << reqPort[2:0];
                  next_r.byteIdx = {1'b0, reqPort[15:3]};
                  next_r.qualOne = {reqPort, 3'h0, reqSegment, reqAddrSize, reqOperandSize,
                     reqRepeat, reqString, 1'b0, reqIsInput};
                  next_r.qualTwo = reqNextRip;
                  next_r.st = r.portEn ? ST_FETCH : ST_DECIDE;
               end
            end
         end
         ST_FETCH:
         begin
            next_r.memReqValid = 1'b1;
            next_r.memAddr = (r.isReg ? r.regBase : r.portBase) + {50'h0, r.byteIdx};
            if (r.memReqValid && memReqReady)
            begin
               next_r.memReqValid = 1'b0;
               next_r.st = ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            if (memRespValid)
            begin
               if (r.second)
                  next_r.hit = r.hit | |(memData & r.bitMask[15:8]);
               else
                  next_r.hit = |(memData & r.bitMask[7:0]);
               if (!r.second && !r.isReg && |r.bitMask[15:8])
               begin
                  next_r.second = 1'b1;
                  next_r.byteIdx = r.byteIdx + 14'h1;
                  next_r.st = ST_FETCH;
               end
               else
                  next_r.st = ST_DECIDE;
            end
         end
         ST_DECIDE:
         begin
            if (r.hit)
            begin
               next_r.respExit = 1'b1;
               next_r.exitCode = r.isReg ? EXIT_REG : EXIT_PORT;
               next_r.qual1 = r.qualOne;
               next_r.qual2 = r.qualTwo;
               next_r.lastInvalid = 1'b0;
            end
            else if (r.postFault)
               next_r.respFault = 1'b1;
            else
               next_r.respExecute = 1'b1;
            next_r.st = ST_DONE;
         end
         ST_DONE:
         begin
            next_r.respValid = 1'b1;
            next_r.st = ST_IDLE;
         end
         default:
            next_r.st = ST_IDLE;
      endcase
      if (r.respValid)
      begin
         next_r.respFault = 1'b0;
         next_r.respExit = 1'b0;
         next_r.respExecute = 1'b0;
         next_r.reqReady = 1'b1;
      end

      // AXI4-Lite write: address and data in either order
      if (s_axi_awvalid && r.awready)
      begin
         next_r.awHeld = 1'b1;
         next_r.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready)
      begin
         next_r.wHeld = 1'b1;
         next_r.wData = s_axi_wdata;
         next_r.wStrb = s_axi_wstrb;
      end
      if (r.awHeld && r.wHeld && !r.bvalid)
      begin
         next_r.awHeld = 1'b0;
         next_r.wHeld = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = RESP_SLVERR;
         if (r.awAddr == ADDR_PA_BITS)
         begin
            next_r.bresp = RESP_OKAY;
            if (r.wStrb[0])
               next_r.paBits = r.wData[6:0];
         end
         else if (r.awAddr == ADDR_QUAL1 || r.awAddr == ADDR_QUAL2_LO || r.awAddr == ADDR_QUAL2_HI
            || r.awAddr == ADDR_STATUS)
            next_r.bresp = RESP_OKAY;
      end
      if (r.bvalid && s_axi_bready)
         next_r.bvalid = 1'b0;
      next_r.awready = !next_r.awHeld && !next_r.bvalid;
      next_r.wready = !next_r.wHeld && !next_r.bvalid;

      // AXI4-Lite read
      next_r.arready = !next_r.rvalid;
      if (s_axi_arvalid && r.arready)
      begin
         rdVal = readReg(r, s_axi_araddr, rdErr);
         next_r.rdata = rdVal;
         next_r.rresp = rdErr ? RESP_SLVERR : RESP_OKAY;
         next_r.rvalid = 1'b1;
         next_r.arready = 1'b0;
      end
      else if (r.rvalid && s_axi_rready)
      begin
         next_r.rvalid = 1'b0;
         next_r.arready = 1'b1;
      end

      if (sys_rst)
      begin
         next_r = '0;
         next_r.st = ST_IDLE;
         next_r.paBits = PA_BITS_RESET;
         next_r.reqReady = 1'b1;
         next_r.awready = 1'b1;
         next_r.wready = 1'b1;
         next_r.arready = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      r <= next_r;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign entryDone = r.entryDone;
   assign entryInvalid = r.entryInvalid;
   assign reqReady = r.reqReady;
   assign respValid = r.respValid;
   assign respFault = r.respFault;
   assign respExit = r.respExit;
   assign respExecute = r.respExecute;
   assign exitCode = r.exitCode;
   assign exitQualifierOne = r.qual1;
   assign exitQualifierTwo = r.qual2;
   assign memReqValid = r.memReqValid;
   assign memAddr = r.memAddr;
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_base_aligned: assert property (entryStart |=>
      r.portBase == ($past(portBitmapBaseAddress) & PAGE_MASK))
      else $error("port map base not loaded page aligned");
   chk_reg_aligned: assert property (entryStart |=>
      r.regBase == ($past(registerBitmapBaseAddress) & PAGE_MASK))
      else $error("register map base not loaded page aligned");
   chk_invalid_code: assert property (entryStart ##1 r.entryInvalid |-> exitCode == EXIT_INVALID)
      else $error("invalid entry without invalid exit code");
   chk_port_disabled: assert property (reqValid && reqReady && !reqIsReg && !reqPreFault && !r.portEn
      && !entryStart |-> ##3 respValid && !respExit)
      else $error("port exit while port intercept disabled");
   chk_reg_disabled: assert property (reqValid && reqReady && reqIsReg && !r.regEn && !entryStart
      |-> ##[2:3] respValid && !respExit)
      else $error("register exit while register intercept disabled");
   chk_pre_fault: assert property (reqValid && reqReady && reqPreFault && !entryStart
      |-> ##2 respValid && respFault && !respExit)
      else $error("early fault not raised before check");
   chk_qual_zero: assert property (respExit && exitCode == EXIT_PORT
      |-> exitQualifierOne[15:13] == 3'h0 && !exitQualifierOne[1])
      else $error("reserved qualifier bits not zero");
   chk_reg_qual: assert property (respExit && exitCode == EXIT_REG |-> exitQualifierOne[31:1] == 31'h0)
      else $error("register qualifier not 0 or 1");
   chk_unmapped_hit: assert property (reqValid && reqReady && reqIsReg && r.regEn && !reqPreFault
      && !entryStart && reqRegNum[31:13] == 19'h7ffff |-> ##3 respValid && respExit)
      else $error("unmapped register not intercepted");
   chk_one_answer: assert property (respValid |-> $onehot({respFault, respExit, respExecute}))
      else $error("answer not exactly one outcome");
endmodule

// >>> rtl/ioms_pkg.sv
// Constants, state codes and layouts of the port and register intercept checker.
// Assumes one core clock, a synchronous reset and an AXI4-Lite master for status.
// Summary of operation
// - Port map: 12 KB, 64K+3 meaningful bits
// - Port map base latched at entry, 4K aligned
// - Map end beyond physical limit: invalid exit
// - Port bit n set intercepts port n
// - Port map used only when enabled
// - Multi-byte access: any set bit intercepts
// - Mode, privilege, task-map faults precede check
// - Qualifier holds port, segment, zero bits 15-13
// - Qualifier flags address and operand size
// - Qualifier flags repeat, string; bit 1 zero
// - Qualifier bit 0: 1 input, 0 output
// - Second qualifier holds next instruction pointer
// - Register map: four 2 KB sub-maps, 8 KB
// - Three register ranges map to byte offsets
// - Lower bit read, higher bit write intercept
// - Unmapped register intercepted when enabled
// - Register intercept disabled: never intercept
// - Common faults, then map check, then specific
// - Register qualifier: 0 read, 1 write
// - Register map base latched at entry, 4K aligned
package ioms_pkg;
   localparam int PA_W = 64;
   localparam logic [PA_W-1:0] PAGE_MASK = 64'hffff_ffff_ffff_f000;
   localparam logic [PA_W-1:0] PORT_MAP_LAST = 64'h0000_0000_0000_2fff;
   localparam logic [PA_W-1:0] REG_MAP_LAST = 64'h0000_0000_0000_1fff;
   localparam logic [6:0] PA_BITS_RESET = 7'h30;
   localparam logic [15:0] EXIT_PORT = 16'h007b;
   localparam logic [15:0] EXIT_REG = 16'h007c;
   localparam logic [15:0] EXIT_INVALID = 16'hffff;
   localparam logic [12:0] REG_OFF_LOW = 13'h0000;
   localparam logic [12:0] REG_OFF_HI0 = 13'h0800;
   localparam logic [12:0] REG_OFF_HI1 = 13'h1000;
   localparam logic [18:0] REG_RANGE_LOW = 19'h00000;
   localparam logic [18:0] REG_RANGE_HI0 = 19'h60000;
   localparam logic [18:0] REG_RANGE_HI1 = 19'h60008;
   localparam logic [7:0] ADDR_QUAL1 = 8'h00;
   localparam logic [7:0] ADDR_QUAL2_LO = 8'h04;
   localparam logic [7:0] ADDR_QUAL2_HI = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_PA_BITS = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_FETCH = 3'h1,
      ST_WAIT = 3'h2,
      ST_DECIDE = 3'h3,
      ST_DONE = 3'h4
   } ioms_state_t;
endpackage

// >>> tb/ioms_mem_model.sv
// Byte-wide memory model holding both permission maps.
// Assumes the checker holds each request until it sees memReqReady.
`timescale 1ns/1ns
module ioms_mem_model
(
   // Clock and pacing
   input wire logic clk,
   input wire logic slow,
   // Byte read port
   input wire logic memReqValid,
   input wire logic [63:0] memAddr,
   output logic memReqReady,
   output logic memRespValid,
   output logic [7:0] memData
);
   logic [63:0] held;
   logic busy;
   int delay;

   // Map contents as a fixed pattern of the address
   function automatic logic [7:0] map_byte(input logic [63:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h6c;
   endfunction

   initial
   begin
      memReqReady = 1'b0;
      memRespValid = 1'b0;
      memData = 8'h00;
      busy = 1'b0;
      delay = 0;
   end

   always @(posedge clk)
   begin
      memRespValid <= 1'b0;
      // Stale data never repeats after the answer
      if (memRespValid)
         memData <= ~memData;
      if (busy)
      begin
         if (delay == 0)
         begin
            memRespValid <= 1'b1;
            memData <= map_byte(held);
            busy <= 1'b0;
         end
         else
            delay <= delay - 1;
      end
      else if (memReqValid && memReqReady)
      begin
         held <= memAddr;
         busy <= 1'b1;
         memReqReady <= 1'b0;
         delay <= slow ? 4 : 0;
      end
      else
         memReqReady <= !slow || !memReqReady;
   end
endmodule

// >>> tb/test_ioms_intercept_check.sv
// Self-checking bench for the port and register intercept checker.
// Assumes the memory model answers every permission map read.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin errors++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_ioms_intercept_check
   import ioms_pkg::*;
();
   // ******************************************
   // Signals
   // ******************************************
   typedef struct {logic [2:0] kind; logic [15:0] code; logic [31:0] q1; logic [63:0] q2;} ioms_exp_t;
   logic clk = 1'b0, sys_rst = 1'b1, entryStart = 1'b0, portIoInterceptEnable = 1'b0, registerInterceptEnable = 1'b0;
   logic [63:0] portBitmapBaseAddress = '0, registerBitmapBaseAddress = '0, reqNextRip = '0, memAddr, exitQualifierTwo;
   logic reqValid = 1'b0, reqIsReg = 1'b0, reqRepeat = 1'b0, reqString = 1'b0, reqIsInput = 1'b0, reqRegWrite = 1'b0;
   logic reqPreFault = 1'b0, reqPostFault = 1'b0, slow = 1'b0, entryDone, entryInvalid, reqReady, respValid;
   logic respFault, respExit, respExecute, memReqValid, memReqReady, memRespValid;
   logic [15:0] reqPort = '0, exitCode, lastCode = '0;
   logic [2:0] reqOperandSize = 3'h1, reqAddrSize = 3'h1, reqSegment = 3'h0;
   logic [31:0] reqRegNum = '0, exitQualifierOne, s_axi_wdata = '0, s_axi_rdata, lastQ1 = '0;
   logic s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0, s_axi_wready, s_axi_bvalid, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_arready, s_axi_rvalid, s_axi_rready = 1'b0, pEn = 1'b0, rEn = 1'b0;
   logic [7:0] memData, s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [63:0] pBase = '0, rBase = '0, lastQ2 = '0, pb, rb;
   logic [31:0] regPick [8] = '{32'h0, 32'hc000_0000, 32'hc001_0000, 32'h2000, 32'hc000_2000, 32'hc001_2000,
      32'hbfff_e000, 32'hffff_e000};
   logic [63:0] invPb [6] = '{64'hffff_ffff_dfff, 64'hffff_ffff_e000, '0, '0, 64'hffff_dfff, '0};
   logic [63:0] invRb [6] = '{'0, '0, 64'hffff_ffff_efff, 64'hffff_ffff_f000, '0, 64'hffff_f000};
   ioms_exp_t expQ[$];
   ioms_exp_t e;
   int errors = 0;
   int checksDone = 0;

   ioms_intercept_check i_ioms_intercept_check (.*);
   ioms_mem_model i_ioms_mem_model (.*);

   always #4 clk = ~clk;

   // ******************************************
   // Tasks
   // ******************************************
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checksDone, errors);
      if (errors == 0 && checksDone > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exResp);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK("write response", exResp, s_axi_bresp)
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] exResp);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK("read data", ex, s_axi_rdata)
      `CHK("read response", exResp, s_axi_rresp)
   endtask

   task automatic enter(input logic [63:0] bp, input logic [63:0] br, input logic pe, input logic re, input logic inv);
      @(posedge clk);
      entryStart <= 1'b1;
      portBitmapBaseAddress <= bp;
      registerBitmapBaseAddress <= br;
      portIoInterceptEnable <= pe;
      registerInterceptEnable <= re;
      @(posedge clk);
      entryStart <= 1'b0;
      @(posedge clk);
      `CHK("entry done", 1'b1, entryDone)
      `CHK("entry invalid", inv, entryInvalid)
      pBase = bp;
      rBase = br;
      pEn = pe;
      rEn = re;
   endtask

   task automatic request(input logic isReg, input logic [15:0] p, input logic [31:0] r, input logic pre, input logic post);
      ioms_exp_t x;
      logic [2:0] os, as, segField;
      logic w, hit, in, repeated, stringOp;
      logic [7:0] b;
      logic [16:0] k;
      logic [12:0] off;
      logic [63:0] rip;
      int n;
      os = 3'h1 << ($urandom % 3);
      as = 3'h1 << ($urandom % 3);
      segField = 3'($urandom);
      {w, in, repeated, stringOp} = 4'($urandom);
      rip = {$urandom, $urandom};
      hit = 1'b0;
      if (!isReg)
         for (int i = 0; i < (os[2] ? 4 : os[1] ? 2 : 1); i++)
         begin
            k = 17'(p) + 17'(i);
            b = i_ioms_mem_model.map_byte((pBase & PAGE_MASK) + 64'(k[16:3]));
            hit = hit | b[k[2:0]];
         end
      else
      begin
         off = r[31:16] == 16'hc000 ? REG_OFF_HI0 : r[31:16] == 16'hc001 ? REG_OFF_HI1 : REG_OFF_LOW;
         b = i_ioms_mem_model.map_byte((rBase & PAGE_MASK) + 64'(off) + 64'(r[12:2]));
         hit = b[{r[1:0], w}] || r[15:13] != 3'h0 || !(r[31:16] inside {16'h0, 16'hc000, 16'hc001});
      end
      hit = hit && (isReg ? rEn : pEn);
      x.kind = pre ? 3'b100 : hit ? 3'b010 : post ? 3'b100 : 3'b001;
      x.code = isReg ? EXIT_REG : EXIT_PORT;
      x.q1 = isReg ? {31'h0, w} : {p, 3'h0, segField, as, os, repeated, stringOp, 1'b0, in};
      x.q2 = rip;
      if (x.kind == 3'b010)
      begin
         lastQ1 = x.q1;
         lastQ2 = rip;
         lastCode = x.code;
      end
      reqValid <= 1'b1;
      reqIsReg <= isReg;
      reqPort <= p;
      reqRegNum <= r;
      reqRegWrite <= w;
      reqOperandSize <= os;
      reqAddrSize <= as;
      reqSegment <= segField;
      {reqIsInput, reqRepeat, reqString} <= {in, repeated, stringOp};
      reqNextRip <= rip;
      {reqPreFault, reqPostFault} <= {pre, post};
      slow <= 1'($urandom);
      do
         @(posedge clk);
      while (reqReady !== 1'b1);
      expQ.push_back(x);
      reqValid <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (respValid !== 1'b1 && n < 300);
      `CHK("answer in time", 1'b1, respValid)
   endtask

   // ******************************************
   // Checking and sequence
   // ******************************************
   always @(posedge clk)
   begin
      if (respValid === 1'b1)
      begin
         if (expQ.size() == 0)
         begin
            errors++;
            $display("mismatch response exp none got one");
         end
         else
         begin
            e = expQ.pop_front();
            `CHK("outcome", e.kind, {respFault, respExit, respExecute})
            if (e.kind == 3'b010)
            begin
               `CHK("exit code", e.code, exitCode)
               `CHK("qualifier one", e.q1, exitQualifierOne)
               if (e.code == EXIT_PORT)
                  `CHK("qualifier two", e.q2, exitQualifierTwo)
            end
         end
      end
   end

   initial
   begin
      repeat (50000) @(posedge clk);
      errors++;
      report_and_stop();
   end

   initial
   begin
      void'($urandom(34953));
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      axi_read(ADDR_PA_BITS, 32'h30, RESP_OKAY);
      axi_read(ADDR_QUAL1, 32'h0, RESP_OKAY);
      axi_write(ADDR_QUAL1, 32'hffff_ffff, RESP_OKAY);
      axi_read(ADDR_QUAL1, 32'h0, RESP_OKAY);
      axi_write(8'h40, 32'h1, RESP_SLVERR);
      axi_read(8'h40, 32'h0, RESP_SLVERR);
      pb = {24'h0, 8'($urandom), $urandom};
      rb = {24'h0, 8'($urandom), $urandom};
      enter(pb, rb, 1'b1, 1'b1, 1'b0);
      for (int i = 0; i < 48; i++)
         request(1'b0, i < 4 ? 16'hfffc + 16'(i) : 16'($urandom), '0, $urandom % 6 == 0, $urandom % 5 == 0);
      axi_read(ADDR_QUAL1, lastQ1, RESP_OKAY);
      axi_read(ADDR_QUAL2_LO, lastQ2[31:0], RESP_OKAY);
      axi_read(ADDR_QUAL2_HI, lastQ2[63:32], RESP_OKAY);
      axi_read(ADDR_STATUS, {16'h0, lastCode}, RESP_OKAY);
      for (int i = 0; i < 48; i++)
         request(1'b1, '0, regPick[i % 8] + (i < 8 ? 32'h0 : i < 16 ? 32'h1fff : 32'($urandom % 8192)),
            $urandom % 6 == 0, $urandom % 5 == 0);
      enter(pb, rb, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 8; i++)
         request(1'(i), 16'($urandom), $urandom, 1'b0, i > 5);
      for (int i = 0; i < 6; i++)
      begin
         if (i == 4)
            axi_write(ADDR_PA_BITS, 32'h20, RESP_OKAY);
         enter(invPb[i], invRb[i], 1'b1, 1'b1, i % 2 == 1);
      end
      axi_read(ADDR_STATUS, {15'h0, 1'b1, EXIT_INVALID}, RESP_OKAY);
      axi_read(ADDR_PA_BITS, 32'h20, RESP_OKAY);
      repeat (4) @(posedge clk);
      report_and_stop();
   end
endmodule
